// ==== hw/flash_page_lock_and_crc.sv ====
// Flash page lock register with one-way commit, and 8-bit link/ROM CRC
// Behaviour
// - A page lock register sits at address 101 hex and governs flash program and erase per page.
// - A program or erase aimed at a page whose lock bit is zero is refused.
// - Lock bits only ever go from one to zero; only i_srst restores a committed bit.
// - A lock value is staged by a memory write and committed only on program code 5A hex.
// - Bit 0 guards bytes 00-1F, each higher bit the next 32 bytes up to bit 6, bit 7 reserved.
// - Bit 6 guards bytes C0 through DF, the topmost page.
// - The top byte of the 64-bit identity ROM holds the CRC of the lower 56 bits.
// - Every CRC uses the polynomial x^8 + x^5 + x^4 + 1.
// - For write and page erase commands the CRC covers command, address and data bytes.
// - For read commands the CRC covers command and address bytes.
// - A CRC mismatch never aborts or blocks a command sequence here.
`timescale 1ns/100ps
`default_nettype none
module flash_page_lock_and_crc #(
  parameter logic [55:0] ROM_ID = flash_page_lock_pkg::ROM_ID_DEFAULT
) (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_srst,
  // Memory write bytes from the command decoder
  input  wire logic        i_wr_valid,
  input  wire logic [8:0]  i_wr_addr,
  input  wire logic [7:0]  i_wr_data,
  // Program code byte after CRC verification
  input  wire logic        i_prog_valid,
  input  wire logic [7:0]  i_prog_code,
  // Flash program or erase request
  input  wire logic        i_flash_req,
  input  wire logic [7:0]  i_flash_addr,
  // CRC byte stream
  input  wire logic        i_crc_clear,
  input  wire logic        i_crc_valid,
  input  wire logic [7:0]  i_crc_byte,
  // Results
  output logic             o_flash_grant,
  output logic             o_flash_deny,
  output logic [7:0]       o_flash_page_lock,
  output logic [7:0]       o_crc_value,
  output logic [63:0]      o_rom_image
);

  // One byte through the CRC, LSB first
  function automatic logic [7:0] crc_byte(input logic [7:0] crc,
                                          input logic [7:0] data);
    logic [7:0] c;
    logic       fb;
    c  = crc;
    fb = 1'b0;
    for (int i = 0; i < 8; i++) begin
      fb = c[0] ^ data[i];
      c  = {1'b0, c[7:1]};
      if (fb) begin
        c = c ^ flash_page_lock_pkg::CRC_POLY_REFL;
      end
    end
    return c;
  endfunction

  function automatic logic [7:0] crc_id(input logic [55:0] id);
    logic [7:0] c;
    c = flash_page_lock_pkg::CRC_SEED;
    for (int b = 0; b < 7; b++) begin
      c = crc_byte(c, id[8*b +: 8]);
    end
    return c;
  endfunction

  localparam logic [7:0] ROM_CRC = crc_id(ROM_ID);

  flash_page_lock_pkg::lock_state_t state_reg;
  flash_page_lock_pkg::lock_state_t state_next;

  logic [7:0] lock_reg;
  logic [7:0] lock_next;
  logic [7:0] staged_reg;
  logic [7:0] crc_reg;
  logic [7:0] crc_next;
  logic       grant_reg;
  logic       deny_reg;
  logic [63:0] rom_reg;

  // Decode
  wire        lock_addr_hit = i_wr_valid &&
                              (i_wr_addr == flash_page_lock_pkg::LOCK_REG_ADDR);
  wire        code_ok       = i_prog_valid &&
                              (i_prog_code == flash_page_lock_pkg::PROGRAM_CODE);
  wire [7:0]  page_sel      = i_flash_addr >> flash_page_lock_pkg::PAGE_SHIFT;
  wire        addr_in_range = i_flash_addr <= flash_page_lock_pkg::FLASH_LAST_ADDR;
  wire        page_open     = addr_in_range && lock_reg[page_sel[2:0]];

  // Staged bits may only clear; bit 7 is held low
  assign lock_next = lock_reg & staged_reg &
                     ~(8'h01 << flash_page_lock_pkg::LOCK_RSVD_BIT);

  // CRC update: clear has priority so a new sequence starts clean
  assign crc_next = i_crc_clear ? flash_page_lock_pkg::CRC_SEED :
                    i_crc_valid ? crc_byte(crc_reg, i_crc_byte) :
                    crc_reg;

  // Commit depends only on a staged lock write and the program code, never on CRC agreement
  always_comb begin
    case (state_reg)
      flash_page_lock_pkg::LOCK_IDLE: begin
        state_next = lock_addr_hit ? flash_page_lock_pkg::LOCK_STAGED
                                   : flash_page_lock_pkg::LOCK_IDLE;
      end
      flash_page_lock_pkg::LOCK_STAGED: begin
        if (code_ok) begin
          state_next = flash_page_lock_pkg::LOCK_COMMIT;
        end else if (i_prog_valid) begin
          state_next = flash_page_lock_pkg::LOCK_IDLE;
        end else begin
          state_next = flash_page_lock_pkg::LOCK_STAGED;
        end
      end
      flash_page_lock_pkg::LOCK_COMMIT: begin
        state_next = flash_page_lock_pkg::LOCK_IDLE;
      end
      default: begin
        state_next = flash_page_lock_pkg::LOCK_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state_reg <= flash_page_lock_pkg::LOCK_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Newest write to the lock address wins while staged
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      staged_reg <= flash_page_lock_pkg::LOCK_RESET_VALUE;
    end else if (lock_addr_hit) begin
      staged_reg <= i_wr_data;
    end
  end

  // Reset models power-up of the nonvolatile cell
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      lock_reg <= flash_page_lock_pkg::LOCK_RESET_VALUE;
    end else if (state_reg == flash_page_lock_pkg::LOCK_COMMIT) begin
      lock_reg <= lock_next;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      grant_reg <= 1'b0;
      deny_reg  <= 1'b0;
    end else begin
      grant_reg <= i_flash_req && page_open;
      deny_reg  <= i_flash_req && !page_open;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      crc_reg <= flash_page_lock_pkg::CRC_SEED;
    end else begin
      crc_reg <= crc_next;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      rom_reg <= 64'h0;
    end else begin
      rom_reg <= {ROM_CRC, ROM_ID};
    end
  end

  assign o_flash_grant     = grant_reg;
  assign o_flash_deny      = deny_reg;
  assign o_flash_page_lock = lock_reg;
  assign o_crc_value       = crc_reg;
  assign o_rom_image       = rom_reg;

  // Checks
  chk_lock_one_way: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (~$past(lock_reg) & lock_reg) == 8'h00)
    else $error("lock bit returned to one");

  chk_lock_commit_code: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (lock_reg != $past(lock_reg)) |-> $past(code_ok, 2))
    else $error("lock changed without program code");

  chk_deny_locked_page: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_flash_req && addr_in_range && !lock_reg[page_sel[2:0]])
      |=> (o_flash_deny && !o_flash_grant))
    else $error("locked page access not refused");

  chk_grant_open_page: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_flash_req && i_flash_addr <= 8'h1F && lock_reg[0]) |=> o_flash_grant)
    else $error("open first page refused");

  chk_top_page_guard: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_flash_req && i_flash_addr >= 8'hC0 && i_flash_addr <= 8'hDF)
      |=> (o_flash_grant == $past(lock_reg[6])))
    else $error("top page not guarded by bit 6");

  chk_reserved_low: assert property (@(posedge i_core_clk) disable iff (i_srst)
    $past(state_reg) == flash_page_lock_pkg::LOCK_COMMIT |-> !lock_reg[7])
    else $error("reserved lock bit set");

  chk_crc_clear_zero: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_crc_clear |=> (o_crc_value == 8'h00))
    else $error("crc not cleared to zero");

  chk_crc_step_poly: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_crc_valid && !i_crc_clear)
      |=> (o_crc_value == crc_byte($past(o_crc_value), $past(i_crc_byte))))
    else $error("crc step wrong");

  chk_rom_crc_byte: assert property (@(posedge i_core_clk) disable iff (i_srst)
    $past(!i_srst) |-> (o_rom_image[63:56] == crc_id(o_rom_image[55:0])))
    else $error("rom crc byte wrong");

  chk_no_crc_block: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (state_reg == flash_page_lock_pkg::LOCK_STAGED && code_ok)
      |=> ##1 (lock_reg == ($past(lock_reg) & $past(staged_reg) & 8'h7F)))
    else $error("commit blocked");

endmodule
`default_nettype wire

// ==== hw/flash_page_lock_pkg.sv ====
// Constants for the flash page lock register and the link CRC generator
package flash_page_lock_pkg;
  // Register map
  localparam logic [8:0] LOCK_REG_ADDR    = 9'h101;
  localparam logic [7:0] LOCK_RESET_VALUE = 8'h7F;
  localparam int         LOCK_RSVD_BIT    = 7;
  localparam int         LOCK_PAGE_COUNT  = 7;
  // Program code that commits a staged lock value
  localparam logic [7:0] PROGRAM_CODE     = 8'h5A;
  // Flash array geometry: 32-byte pages, 224 bytes in all
  localparam int         PAGE_SHIFT       = 5;
  localparam logic [7:0] FLASH_LAST_ADDR  = 8'hDF;
  // CRC: x^8 + x^5 + x^4 + 1, reflected form, zero seed
  localparam logic [7:0] CRC_POLY_REFL    = 8'h8C;
  localparam logic [7:0] CRC_SEED         = 8'h00;
  // Identity ROM: 56 id bits, CRC in the top byte
  localparam int         ROM_ID_BITS      = 56;
  // Arbitrary neutral serial value
  localparam logic [55:0] ROM_ID_DEFAULT  = 56'h00_0000_1234_5601;

  typedef enum logic [1:0] {
    LOCK_IDLE   = 2'b00,
    LOCK_STAGED = 2'b01,
    LOCK_COMMIT = 2'b11
  } lock_state_t;
endpackage

// ==== verification/flash_page_lock_and_crc_tb.sv ====
// Self-checking bench for the flash page lock and CRC block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((e) !== (s)) begin bad_count++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module flash_page_lock_and_crc_tb;
  // Arbitrary identity value
  localparam logic [55:0] ID = 56'hA5_3C96_0F1E_2D4B;
  logic clk = 1'b0, srst = 1'b1, wv = 1'b0, pv = 1'b0, fr = 1'b0;
  logic st = 1'b0, sn = 1'b0, cc, cv, gr, dn;
  logic [8:0] wa = 9'h000;
  logic [7:0] wd = 8'h00, pc = 8'h00, fa = 8'h00, bt = 8'h00;
  logic [7:0] cb, lk, crc, hc, lock_exp;
  logic [63:0] rom;
  logic [1:0] q[$], e;
  logic [31:0] x = 32'h00005FE0;
  int bad_count = 0, checks = 0;
  always #20 clk = ~clk;
  flash_page_lock_and_crc #(.ROM_ID(ID)) dut (
    .i_core_clk(clk), .i_srst(srst), .i_wr_valid(wv), .i_wr_addr(wa),
    .i_wr_data(wd), .i_prog_valid(pv), .i_prog_code(pc),
    .i_flash_req(fr), .i_flash_addr(fa), .i_crc_clear(cc),
    .i_crc_valid(cv), .i_crc_byte(cb), .o_flash_grant(gr),
    .o_flash_deny(dn), .o_flash_page_lock(lk), .o_crc_value(crc),
    .o_rom_image(rom));
  host_master_model host (.i_core_clk(clk), .i_start(st), .i_send(sn),
    .i_byte(bt), .o_crc_clear(cc), .o_crc_valid(cv), .o_crc_byte(cb),
    .o_host_crc(hc));
  function logic [7:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x[7:0];
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic end_sim();
    if (bad_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic lock_wr(logic [8:0] a, logic [7:0] d, logic [7:0] c);
    @(posedge clk);
    wv <= 1'b1; wa <= a; wd <= d;
    @(posedge clk);
    wv <= 1'b0;
    @(posedge clk);
    pv <= 1'b1; pc <= c;
    @(posedge clk);
    pv <= 1'b0;
    if (a == 9'h101 && c == 8'h5A) lock_exp = lock_exp & d & 8'h7F;
    tick(2);
    @(negedge clk);
    `CHK("lock", lock_exp, lk)
  endtask
  // Request stays raised across calls for back-to-back traffic
  task automatic req(logic [7:0] a);
    logic g;
    g = (a <= 8'hDF) && lock_exp[a[7:5]];
    @(posedge clk);
    fr <= 1'b1; fa <= a;
    q.push_back({g, !g});
  endtask
  task automatic crc_seq(int n, logic [55:0] v);
    @(posedge clk);
    // Byte beside the clear must be dropped on both sides
    st <= 1'b1; sn <= 1'b1; bt <= 8'hFF;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      st <= 1'b0; sn <= 1'b1; bt <= v[8*i +: 8];
    end
    @(posedge clk);
    sn <= 1'b0;
    tick(2);
    @(negedge clk);
    `CHK("crc", hc, crc)
  endtask
  always @(negedge clk) begin
    if (gr === 1'b1 || dn === 1'b1) begin
      e = (q.size() > 0) ? q.pop_front() : 2'b00;
      `CHK("grant_deny", e, {gr, dn})
    end
  end
  initial begin
    tick(6000);
    bad_count++;
    end_sim();
  end
  initial begin
    lock_exp = 8'h7F;
    tick(10);
    srst <= 1'b0;
    tick(2);
    @(negedge clk);
    `CHK("reset_lock", 8'h7F, lk)
    crc_seq(1, 56'h00_0000_0000_0001);
    `CHK("crc_ref", 8'h5E, crc)
    crc_seq(7, ID);
    `CHK("rom", {hc, ID}, rom)
    for (int n = 2; n < 8; n++)
      crc_seq(n, {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()});
    lock_wr(9'h100, 8'h00, 8'h5A);
    lock_wr(9'h101, 8'h00, 8'hA5);
    lock_wr(9'h101, 8'hFF, 8'h5A);
    for (int k = 0; k < 8; k++) begin
      lock_wr(9'h101, (k == 7) ? 8'hFF : ~(8'h01 << k), 8'h5A);
      for (int j = 0; j < 20; j++)
        req(j == 0 ? {3'(k), 5'h00} : j == 1 ? {3'(k), 5'h1F} : rnd());
      @(posedge clk);
      fr <= 1'b0;
      tick(2);
    end
    `CHK("queue_empty", 1'b1, q.size() == 0)
    end_sim();
  end
endmodule
`default_nettype wire

// ==== verification/host_master_model.sv ====
// Host bus master model: streams checked bytes, keeps its own CRC
`timescale 1ns/100ps
`default_nettype none
module host_master_model (
  // Commands from the bench
  input  wire logic       i_core_clk,
  input  wire logic       i_start,
  input  wire logic       i_send,
  input  wire logic [7:0] i_byte,
  // Byte stream into the device, and the host's own CRC
  output logic            o_crc_clear,
  output logic            o_crc_valid,
  output logic [7:0]      o_crc_byte,
  output logic [7:0]      o_host_crc
);
  logic [7:0] c;
  always @(posedge i_core_clk) begin
    o_crc_clear <= i_start;
    o_crc_valid <= i_send;
    // Idle data toggles so a stale byte is never mistaken for a live one
    o_crc_byte  <= i_send ? i_byte : ~i_byte;
    if (i_start) begin
      o_host_crc <= 8'h00;
    end else if (i_send) begin
      c = o_host_crc;
      for (int i = 0; i < 8; i++)
        c = (c >> 1) ^ ((c[0] ^ i_byte[i]) ? 8'h8C : 8'h00);
      o_host_crc <= c;
    end
  end
endmodule
`default_nettype wire
